// *** csd_defines.svh ***
// Register offsets, field positions, reset values and encodings of the clock switch block
`ifndef CSD_DEFINES_SVH
`define CSD_DEFINES_SVH

// Register offsets on the plain register port
`define CSD_ADDR_REQ 3'h0
`define CSD_ADDR_CUR 3'h1
`define CSD_ADDR_CTL 3'h2
`define CSD_ADDR_IST 3'h3
`define CSD_ADDR_IMSK 3'h4

// Field positions of the switch control and status register
`define CSD_CTL_HOLD 7
`define CSD_CTL_PWR 6
`define CSD_CTL_BYP 5
`define CSD_CTL_DONE 4
`define CSD_CTL_NRDY 3

// Interrupt event bits
`define CSD_EV_HELD 0
`define CSD_EV_DONE 1
`define CSD_EV_W 2

// Source field encodings
`define CSD_SRC_EXT 3'h7
`define CSD_SRC_HF1M 3'h6
`define CSD_SRC_RSV5 3'h5
`define CSD_SRC_LF 3'h4
`define CSD_SRC_SEC 3'h3
`define CSD_SRC_RSV2 3'h2
`define CSD_SRC_EXT4X 3'h1
`define CSD_SRC_HF32M 3'h0

// Divider field: codes above this one are reserved and divide by one
`define CSD_DIV_MAX 4'h9

// Reset values
`define CSD_RST_SRC 3'h6
`define CSD_RST_DIV 4'h0
`define CSD_RST_BYTE 8'h00

`endif

// *** csd_pkg.sv ***
// Types shared by the clock switch block
package csd_pkg;
  typedef logic [2:0] csd_src_t;
  typedef logic [3:0] csd_div_t;
  typedef logic [2:0] csd_addr_t;
  typedef logic [7:0] csd_byte_t;
  typedef logic [2:0] csd_cfg_t;
  typedef enum logic [1:0] {CSD_IDLE, CSD_WAIT, CSD_HELD, CSD_ALIGN} csd_state_e;
endpackage

// *** csd_postscaler.sv ***
// Postscaler: turns the current divider code into a clock enable with whole periods only
`timescale 1ns/10ps
`default_nettype none
`include "csd_defines.svh"
module csd_postscaler (
  input wire logic clk,
  input wire logic rst_b,
  input wire csd_pkg::csd_div_t div_code,
  output logic tick,
  output logic boundary
);
  import csd_pkg::*;

  typedef struct packed {
    logic [8:0] cnt;
    logic tick;
  } csd_ps_s;

  csd_ps_s s_r;
  csd_ps_s s_nxt;
  logic [8:0] reload;

  always_comb begin
    if (div_code > `CSD_DIV_MAX) begin
      reload = 9'h000; // Reserved codes run undivided
    end else begin
      reload = 9'(({9'h000, 1'b1} << div_code) - 10'h001);
    end
  end

  // Reload only at the end of a period, so no period is ever cut short
  always_comb begin
    s_nxt = s_r;
    s_nxt.tick = (s_r.cnt == 9'h000);
    if (s_r.cnt == 9'h000) begin
      s_nxt.cnt = reload;
    end else begin
      s_nxt.cnt = s_r.cnt - 9'h001;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign tick = s_r.tick;
  assign boundary = (s_r.cnt == 9'h000);

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  AST_DIV_BY_ONE: assert property ((div_code == 4'h0 && s_r.cnt == 9'h000) |=> tick)
    else $error("Divide by one lost a tick");
  AST_DIV_BY_TWO: assert property ((div_code == 4'h1 && tick && s_r.cnt == 9'h001)
    |=> !tick ##1 tick)
    else $error("Divide by two period wrong");
endmodule // csd_postscaler
`default_nettype wire

// *** csd_clock_switch.sv ***
// Clock switch control, secondary oscillator settings and switch status registers
//
// Design decisions made here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "csd_defines.svh"
module csd_clock_switch (
  input wire logic clk,
  input wire logic rst_b,
  input wire csd_pkg::csd_addr_t reg_addr,
  input wire csd_pkg::csd_byte_t reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [7:0] osc_ready,
  input wire csd_pkg::csd_cfg_t cfg_ext_osc,
  output csd_pkg::csd_cfg_t external_osc_config,
  output csd_pkg::csd_src_t current_source,
  output csd_pkg::csd_div_t current_divider,
  output logic sys_clk_en,
  output logic secondary_oscillator_high_power,
  output logic secondary_oscillator_bypass,
  output logic secondary_out_pin_oe,
  output logic irq
);
  import csd_pkg::*;

  typedef struct packed {
    csd_state_e st;
    csd_src_t req_src;
    csd_div_t req_div;
    csd_src_t cur_src;
    csd_div_t cur_div;
    logic hold;
    logic pwr;
    logic byp;
    logic [`CSD_EV_W-1:0] ist;
    logic [`CSD_EV_W-1:0] imsk;
    csd_byte_t rdata;
    logic irq;
    logic hp;
    logic out_oe;
    csd_cfg_t ext_cfg;
    logic cfg_taken;
  } csd_state_s;

  csd_state_s s_r;
  csd_state_s s_nxt;
  logic pending;
  logic sel_ready;
  logic new_rdy;
  logic boundary;
  logic [`CSD_EV_W-1:0] ev;
  csd_byte_t ctl_view;

  // Divider that turns the current divider code into the system clock enable
  csd_postscaler u_post (
    .clk(clk),
    .rst_b(rst_b),
    .div_code(s_r.cur_div),
    .tick(sys_clk_en),
    .boundary(boundary)
  );

  assign pending = (s_r.req_src != s_r.cur_src) || (s_r.req_div != s_r.cur_div);
  // Source code selects ready
  // Reserved codes never reach here, so their ready lines are never consulted
  assign sel_ready = osc_ready[s_r.req_src];
  assign new_rdy = pending && sel_ready;

  assign ctl_view = {s_r.hold, s_r.pwr, s_r.byp, !pending, new_rdy, 3'b000};

  // Next state: register writes, switch sequencing, events and read data
  always_comb begin
    s_nxt = s_r;
    ev = '0;

    // Configuration word
    // Caught once after reset release; runtime writes never touch it
    if (!s_r.cfg_taken) begin
      s_nxt.ext_cfg = cfg_ext_osc;
      s_nxt.cfg_taken = 1'b1;
    end

    // Software writes
    if (reg_wr) begin
      case (reg_addr)
        `CSD_ADDR_REQ: begin
          if (reg_wdata[6:4] == `CSD_SRC_RSV5 || reg_wdata[6:4] == `CSD_SRC_RSV2) begin
            s_nxt.req_src = `CSD_SRC_HF1M;
          end else begin
            s_nxt.req_src = reg_wdata[6:4];
          end
          s_nxt.req_div = reg_wdata[3:0];
        end
        `CSD_ADDR_CTL: begin
          s_nxt.hold = reg_wdata[`CSD_CTL_HOLD];
          s_nxt.pwr = reg_wdata[`CSD_CTL_PWR];
          s_nxt.byp = reg_wdata[`CSD_CTL_BYP];
        end
        `CSD_ADDR_IMSK: begin
          s_nxt.imsk = reg_wdata[`CSD_EV_W-1:0];
        end
        default: begin
        end
      endcase
    end

    // Switch sequencer; decisions use the settled register values
    case (s_r.st)
      CSD_IDLE: begin
        if (pending) begin
          s_nxt.st = CSD_WAIT;
        end
      end
      CSD_WAIT: begin
        if (!pending) begin
          s_nxt.st = CSD_IDLE;
        end else if (sel_ready) begin
          if (s_r.hold) begin
            s_nxt.st = CSD_HELD;
            ev[`CSD_EV_HELD] = 1'b1;
          end else begin
            s_nxt.st = CSD_ALIGN;
          end
        end
      end
      CSD_HELD: begin
        if (!pending) begin
          // Hardware clears hold
          // A withdrawn request releases the hold so later requests are not stuck
          s_nxt.hold = 1'b0;
          s_nxt.st = CSD_IDLE;
        end else if (!s_r.hold) begin
          s_nxt.st = CSD_ALIGN;
        end
      end
      CSD_ALIGN: begin
        if (!pending) begin
          s_nxt.st = CSD_IDLE;
        end else if (!sel_ready) begin
          s_nxt.st = CSD_WAIT; // Source dropped or request changed to a slow one
        end else if (boundary) begin
          // Load at period boundary
          // Changing only when the postscaler wraps avoids a truncated pulse
          s_nxt.cur_src = s_r.req_src;
          s_nxt.cur_div = s_r.req_div;
          ev[`CSD_EV_DONE] = 1'b1;
          s_nxt.st = CSD_IDLE;
        end
      end
      default: begin
        s_nxt.st = CSD_IDLE;
      end
    endcase

    // Sticky events; a read clears, but an event in that cycle wins
    if (reg_rd && reg_addr == `CSD_ADDR_IST) begin
      s_nxt.ist = ev;
    end else begin
      s_nxt.ist = s_r.ist | ev;
    end
    s_nxt.irq = |(s_nxt.ist & s_nxt.imsk);

    s_nxt.hp = s_nxt.pwr && !s_nxt.byp;
    s_nxt.out_oe = !s_nxt.byp;

    // Read data stands only in the cycle after the strobe
    s_nxt.rdata = `CSD_RST_BYTE;
    if (reg_rd) begin
      case (reg_addr)
        `CSD_ADDR_REQ: s_nxt.rdata = {1'b0, s_r.req_src, s_r.req_div};
        `CSD_ADDR_CUR: s_nxt.rdata = {1'b0, s_r.cur_src, s_r.cur_div};
        `CSD_ADDR_CTL: s_nxt.rdata = ctl_view;
        `CSD_ADDR_IST: s_nxt.rdata = {6'h00, s_r.ist};
        `CSD_ADDR_IMSK: s_nxt.rdata = {6'h00, s_r.imsk};
        default: s_nxt.rdata = `CSD_RST_BYTE; // Unmapped reads as zero
      endcase
    end
  end

  // State register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_r.st <= CSD_IDLE;
      s_r.req_src <= `CSD_RST_SRC;
      s_r.req_div <= `CSD_RST_DIV;
      s_r.cur_src <= `CSD_RST_SRC;
      s_r.cur_div <= `CSD_RST_DIV;
      s_r.hold <= 1'b0;
      s_r.pwr <= 1'b0;
      s_r.byp <= 1'b0;
      s_r.ist <= '0;
      s_r.imsk <= '0;
      s_r.rdata <= `CSD_RST_BYTE;
      s_r.irq <= 1'b0;
      s_r.hp <= 1'b0;
      s_r.out_oe <= 1'b1;
      s_r.ext_cfg <= 3'h0;
      s_r.cfg_taken <= 1'b0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs straight from the state flops
  assign reg_rdata = s_r.rdata;
  assign external_osc_config = s_r.ext_cfg;
  assign current_source = s_r.cur_src;
  assign current_divider = s_r.cur_div;
  assign secondary_oscillator_high_power = s_r.hp;
  assign secondary_oscillator_bypass = s_r.byp;
  assign secondary_out_pin_oe = s_r.out_oe;
  assign irq = s_r.irq;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  AST_HOLD_STALLS: assert property ((s_r.st == CSD_HELD && s_r.hold && pending)
    |=> $stable(current_source) && $stable(current_divider))
    else $error("Current fields changed while held");
  AST_HOLD_EVENT: assert property ((s_r.st == CSD_WAIT && pending && sel_ready && s_r.hold)
    |=> s_r.ist[`CSD_EV_HELD] && s_r.st == CSD_HELD)
    else $error("Hold stall raised no event");
  AST_SWITCH_AT_EDGE: assert property (($changed(current_source) || $changed(current_divider))
    |-> $past(boundary) && $past(s_r.st) == CSD_ALIGN && $past(sel_ready))
    else $error("Switch outside a period boundary");
  AST_PROCEED: assert property ((s_r.st == CSD_ALIGN && pending && sel_ready && boundary
    && !(reg_wr && reg_addr == `CSD_ADDR_REQ)) |=> !pending ##0 s_r.ist[`CSD_EV_DONE])
    else $error("Ready switch did not complete");
  AST_PWR_MODE: assert property ((reg_wr && reg_addr == `CSD_ADDR_CTL) |=>
    secondary_oscillator_high_power == ($past(reg_wdata[`CSD_CTL_PWR]) && !$past(reg_wdata[`CSD_CTL_BYP])))
    else $error("Power mode does not follow control write");
  AST_BYPASS_PIN: assert property (secondary_oscillator_bypass |-> !secondary_out_pin_oe)
    else $error("Output pin driven under bypass");
  AST_DONE_READ: assert property ((reg_rd && reg_addr == `CSD_ADDR_CTL)
    |=> reg_rdata[`CSD_CTL_DONE] == !$past(pending)
    && reg_rdata[`CSD_CTL_NRDY] == $past(pending && sel_ready))
    else $error("Status bits read wrong");
  AST_LOW_ZERO: assert property ((reg_rd && reg_addr == `CSD_ADDR_CTL)
    |=> reg_rdata[2:0] == 3'b000)
    else $error("Unimplemented bits read nonzero");
  AST_NO_RSV_SRC: assert property (s_r.req_src != `CSD_SRC_RSV5
    && s_r.req_src != `CSD_SRC_RSV2)
    else $error("Reserved source stored");
  AST_CFG_FIXED: assert property (s_r.cfg_taken && $past(s_r.cfg_taken)
    |-> $stable(external_osc_config))
    else $error("External config changed at run time");
  AST_IRQ_LEVEL: assert property (##1 irq == |(s_r.ist & s_r.imsk))
    else $error("Interrupt does not follow status and mask");

  // Sequencer steps and the loads they allow
  AST_WAIT_PROCEED: assert property ((s_r.st == CSD_WAIT && pending && sel_ready && !s_r.hold)
    |=> s_r.st == CSD_ALIGN)
    else $error("Ready unheld switch did not proceed");
  AST_HELD_RELEASE: assert property ((s_r.st == CSD_HELD && pending && !s_r.hold)
    |=> s_r.st == CSD_ALIGN)
    else $error("Released switch did not proceed");
  AST_WAIT_NO_LOAD: assert property ((s_r.st == CSD_WAIT)
    |=> $stable(current_source) && $stable(current_divider))
    else $error("Current fields loaded before the source was ready");
  AST_DONE_EVENT: assert property (($changed(current_source) || $changed(current_divider))
    |-> s_r.ist[`CSD_EV_DONE])
    else $error("Completed switch raised no done event");
  AST_CUR_VALID_SRC: assert property (current_source != `CSD_SRC_RSV5
    && current_source != `CSD_SRC_RSV2)
    else $error("Reserved source became current");
  AST_CRYSTAL_PIN: assert property (!secondary_oscillator_bypass |-> secondary_out_pin_oe)
    else $error("Output pin idle in crystal mode");
  // Read data must fall back to zero so a stale byte is never taken for an answer
  AST_RDATA_IDLE: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("Read data present without a read");

  COV_HELD: cover property (s_r.st == CSD_HELD ##[1:20] s_r.st == CSD_ALIGN);
  COV_SWITCH: cover property (s_r.st == CSD_ALIGN ##1 s_r.st == CSD_IDLE && !pending);
  COV_IRQ: cover property ($rose(irq));
  COV_DIV_RSV: cover property (current_divider > `CSD_DIV_MAX ##1 sys_clk_en);
  COV_SRC_REMAP: cover property (reg_wr && reg_addr == `CSD_ADDR_REQ
    && reg_wdata[6:4] == `CSD_SRC_RSV5);
endmodule // csd_clock_switch
`default_nettype wire

// *** csd_osc_model.sv ***
// Behavioural model of the selectable oscillator sources behind the clock switch
`timescale 1ns/10ps
`default_nettype none
module csd_osc_model #(
  parameter int START_CYCLES = 3
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [7:0] osc_en,
  output logic [7:0] osc_ready
);
  int cnt [8];
  // Each source reports ready some cycles after enable; drops at once when disabled
  // reserved codes never ready
  always_ff @(posedge clk or negedge rst_b) begin
    for (int i = 0; i < 8; i++) begin
      if (!rst_b || !osc_en[i] || i == 5 || i == 2) begin
        cnt[i] <= 0;
        osc_ready[i] <= 1'b0;
      end else if (cnt[i] < START_CYCLES) begin
        cnt[i] <= cnt[i] + 1;
      end else begin
        osc_ready[i] <= 1'b1;
      end
    end
  end
endmodule // csd_osc_model
`default_nettype wire

// *** test_clock_switch_divider_status.sv ***
// Self-checking bench of the clock switch, divider and status block
`timescale 1ns/10ps
`default_nettype none
`include "csd_defines.svh"
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin errors++; \
  $display("mismatch t=%0t got %h exp %h", $time, (a), (b)); end end
module test_clock_switch_divider_status;
  import csd_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  csd_addr_t reg_addr = 3'h0;
  csd_byte_t reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic [7:0] osc_en = 8'h40;
  logic [7:0] osc_ready;
  csd_cfg_t ext_cfg, cur_src;
  csd_cfg_t cfg_word = 3'h5;
  csd_div_t cur_div;
  logic clk_en, high_pwr, bypass, out_oe, irq;
  int errors = 0;
  int compares = 0;
  int cyc = 0;
  logic [7:0] d;
  always #12.5 clk = ~clk;
  csd_clock_switch u_dut (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .osc_ready(osc_ready), .cfg_ext_osc(cfg_word), .external_osc_config(ext_cfg),
    .current_source(cur_src), .current_divider(cur_div), .sys_clk_en(clk_en),
    .secondary_oscillator_high_power(high_pwr), .secondary_oscillator_bypass(bypass), .secondary_out_pin_oe(out_oe),
    .irq(irq));
  csd_osc_model u_osc (.clk(clk), .rst_b(rst_b), .osc_en(osc_en), .osc_ready(osc_ready));
  task automatic wr(input csd_addr_t a, input csd_byte_t v);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input csd_addr_t a);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // Bounded wait for a completed switch to the given source
  task automatic wait_src(input csd_src_t s);
    for (int i = 0; i < 2000 && cur_src !== s; i++) @(posedge clk);
    #1;
  endtask
  task automatic wait_pulse();
    @(posedge clk);
    #1;
    for (int i = 0; i < 2000 && clk_en !== 1'b1; i++) @(posedge clk) #1;
  endtask
  task automatic conclude();
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Reset values, read-only and unmapped places
  task automatic t_reset();
    `CHK(out_oe, 1'b1)
    rd(`CSD_ADDR_CTL); `CHK(d, 8'h10)
    `CHK(ext_cfg, 3'h5)
    cfg_word <= 3'h2;
    rd(`CSD_ADDR_REQ); `CHK(d, 8'h60)
    `CHK(ext_cfg, 3'h5)
    wr(`CSD_ADDR_CUR, 8'hff);
    rd(`CSD_ADDR_CUR); `CHK(d, 8'h60)
    wr(3'h5, 8'hff);
    rd(3'h5); `CHK(d, 8'h00)
  endtask
  // Power select and bypass settings
  task automatic t_secondary();
    wr(`CSD_ADDR_CTL, 8'h7f);
    rd(`CSD_ADDR_CTL); `CHK(d, 8'h70)
    `CHK({high_pwr, bypass, out_oe}, 3'b010)
    wr(`CSD_ADDR_CTL, 8'h40);
    rd(`CSD_ADDR_CTL); `CHK(d, 8'h50)
    `CHK({high_pwr, bypass, out_oe}, 3'b101)
    wr(`CSD_ADDR_CTL, 8'h00);
    #1 `CHK(high_pwr, 1'b0)
  endtask
  // Held switch raises interrupt, completes on release
  task automatic t_hold();
    wr(`CSD_ADDR_IMSK, 8'h03);
    rd(`CSD_ADDR_IST);
    wr(`CSD_ADDR_CTL, 8'h80);
    wr(`CSD_ADDR_REQ, 8'h30);
    rd(`CSD_ADDR_CTL); `CHK(d, 8'h80)
    osc_en[3] <= 1'b1;
    for (int i = 0; i < 100 && irq !== 1'b1; i++) @(posedge clk);
    rd(`CSD_ADDR_CTL); `CHK(d, 8'h88)
    `CHK(cur_src, 3'h6)
    rd(`CSD_ADDR_IST); `CHK(d, 8'h01)
    @(posedge clk);
    #1 `CHK(irq, 1'b0)
    wr(`CSD_ADDR_CTL, 8'h00);
    wait_src(3'h3); `CHK(cur_src, 3'h3)
    @(posedge clk);
    #1 `CHK(irq, 1'b1)
    rd(`CSD_ADDR_IST); `CHK(d, 8'h02)
    rd(`CSD_ADDR_CUR); `CHK(d, 8'h30)
    rd(`CSD_ADDR_CTL); `CHK(d, 8'h10)
  endtask
  // Every valid source code but SEC (3'h3), a slow start and reserved codes
  task automatic t_sources();
    csd_src_t s [5] = '{3'h7, 3'h6, 3'h4, 3'h1, 3'h0};
    wr(`CSD_ADDR_REQ, 8'h70);
    rd(`CSD_ADDR_CTL); `CHK(d, 8'h00)
    osc_en <= 8'hdb;
    foreach (s[i]) begin
      wr(`CSD_ADDR_REQ, {1'b0, s[i], 4'h0});
      wait_src(s[i]); `CHK(cur_src, s[i])
    end
    wr(`CSD_ADDR_REQ, 8'h50);
    rd(`CSD_ADDR_REQ); `CHK(d, 8'h60)
    wr(`CSD_ADDR_REQ, 8'h20);
    rd(`CSD_ADDR_REQ); `CHK(d, 8'h60)
    wait_src(3'h6); `CHK(cur_src, 3'h6)
  endtask
  // Divider codes 0..10 measured as clock enable spacing
  task automatic t_divider();
    int n;
    for (int k = 0; k <= 10; k++) begin
      wr(`CSD_ADDR_REQ, {4'h6, 4'(k)});
      for (int i = 0; i < 2000 && cur_div !== 4'(k); i++) @(posedge clk);
      `CHK(cur_div, 4'(k))
      wait_pulse();
      wait_pulse();
      n = 0;
      do begin
        @(posedge clk);
        #1 n++;
      end while (clk_en !== 1'b1 && n < 2000);
      `CHK(n, (k < 10) ? (1 << k) : 1)
    end
  endtask
  // Cycle ceiling against a hang
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      errors++;
      conclude();
    end
  end
  initial begin
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    t_reset();
    t_secondary();
    t_hold();
    t_sources();
    t_divider();
    conclude();
  end
endmodule // test_clock_switch_divider_status
`default_nettype wire
